// >>> include/host_pin_pkg.sv
// constants, modes and carrier types for the host-port pin function select
package host_pin_pkg;

  localparam int DATA_PINS  = 8;
  localparam int CTRL_PINS  = 5;
  localparam int PIN_COUNT  = DATA_PINS + CTRL_PINS;
  localparam int ADDR_W     = 8;
  localparam int BUS_W      = 32;
  localparam int HOST_ADDR_W = 10;
  localparam int STROBE_COUNT = 3;

  // register byte offsets
  localparam logic [7:0] OFS_PORT_CONTROL = 8'h00;
  localparam logic [7:0] OFS_PIN_DIRECTION = 8'h04;
  localparam logic [7:0] OFS_GPIO_OUT     = 8'h08;
  localparam logic [7:0] OFS_PIN_LEVEL    = 8'h0C;
  localparam logic [7:0] OFS_STATUS       = 8'h10;

  // port control register fields
  localparam int PC_WIDTH       = 6;
  localparam int PC_HOST_EN     = 0;
  localparam int PC_MUX_BUS     = 1;
  localparam int PC_DOUBLE_STB  = 2;
  localparam int PC_ADDR_STB_HI = 3;
  localparam int PC_DATA_STB_HI = 4;
  localparam int PC_READ_STB_HI = 5;

  // pin positions in the pad vectors
  localparam int PIN_A0_AS  = 8;
  localparam int PIN_A1_A8  = 9;
  localparam int PIN_A2_A9  = 10;
  localparam int PIN_RW_RD  = 11;
  localparam int PIN_DS_WR  = 12;

  // strobe shaper lanes
  localparam int STB_ADDR = 0;
  localparam int STB_READ = 1;
  localparam int STB_DATA = 2;

  // reset values: gpio, all pins inputs, strobes active low
  localparam logic [PC_WIDTH-1:0]  PORT_CONTROL_RESET  = 6'h00;
  localparam logic [PIN_COUNT-1:0] PIN_DIRECTION_RESET = 13'h0000;
  localparam logic [PIN_COUNT-1:0] GPIO_OUT_RESET      = 13'h0000;

  typedef enum logic [1:0] {
    MODE_GPIO       = 2'b00,
    MODE_HOST_PLAIN = 2'b01,
    MODE_HOST_MUX   = 2'b10
  } pin_mode_e;

  typedef struct packed {
    logic [DATA_PINS-1:0]   data;
    logic [HOST_ADDR_W-1:0] addr;
    logic                   rw_select;
    logic                   addr_strobe;
    logic                   addr_strobe_rise;
    logic                   read_strobe;
    logic                   read_strobe_rise;
    logic                   data_strobe;
    logic                   data_strobe_rise;
    logic                   write_strobe;
    logic                   write_strobe_rise;
  } host_side_s;

  typedef struct packed {
    logic [DATA_PINS-1:0] data;
    logic                 drive;
  } host_drive_s;

endpackage

// >>> hw/strobe_shaper.sv
// polarity correction and rising-edge detection for synchronised strobe pins
`timescale 1ns/1ps
module strobe_shaper
  import host_pin_pkg::*;
#(
  parameter int WIDTH = STROBE_COUNT
) (
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic [WIDTH-1:0] level_sync,
  input  wire logic [WIDTH-1:0] invert,
  output logic      [WIDTH-1:0] active,
  output logic      [WIDTH-1:0] rise
);

  logic [WIDTH-1:0] active_reg;
  logic [WIDTH-1:0] active_next;
  logic [WIDTH-1:0] rise_reg;
  logic [WIDTH-1:0] rise_next;

  // inversion before the edge detector keeps the edge meaning "became active"
  assign active_next = level_sync ^ invert;
  assign rise_next   = active_next & ~active_reg;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      active_reg <= '0;
      rise_reg   <= '0;
    end else begin
      active_reg <= active_next;
      rise_reg   <= rise_next;
    end
  end

  assign active = active_reg;
  assign rise   = rise_reg;

endmodule // strobe_shaper

// >>> hw/host_port_pin_function_select.sv
// host-port pin function select: host bus roles or gpio per pin
// How it works
// - each pin takes its function from the port control register setting
// - host, plain bus: eight data pins are bidirectional host data lines 0-7
// - host, muxed bus: eight data pins carry shared address/data lines 0-7
// - gpio: data pins are port bits 0-7, direction per bit from direction register
// - gpio: address/strobe pins are port bits 8-12, direction per bit
// - plain bus: first address/strobe pin is host address bit 0
// - muxed bus: first pin is address strobe with selectable polarity
// - second address pin: address bit 1 plain, address bit 8 muxed
// - third address pin: address bit 2 plain, address bit 9 muxed
// - single strobe mode: direction pin is sampled as read/write select
// - double strobe mode: direction pin is read strobe with selectable polarity
// - single strobe mode: strobe pin is common data strobe, programmable polarity
// - double strobe mode: strobe pin is write strobe, programmable polarity
// - stop mode disconnects every gpio input so no pin value reaches the core
//
// Added by the designer: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
module host_port_pin_function_select
  import host_pin_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 rst_b,
  input  wire logic [ADDR_W-1:0]    bus_addr,
  input  wire logic [BUS_W-1:0]     bus_wdata,
  input  wire logic                 bus_write,
  input  wire logic                 bus_read,
  output logic      [BUS_W-1:0]     bus_rdata,
  input  wire logic                 stop_mode,
  input  wire host_drive_s          host_drive,
  output host_side_s                host_side,
  input  wire logic [PIN_COUNT-1:0] pad_in,
  output logic      [PIN_COUNT-1:0] pad_out,
  output logic      [PIN_COUNT-1:0] pad_oe
);

  // registers
  logic [PC_WIDTH-1:0]  port_control_reg;
  logic [PIN_COUNT-1:0] pin_direction_reg;
  logic [PIN_COUNT-1:0] gpio_out_reg;
  logic [PIN_COUNT-1:0] pin_level_reg;
  logic [BUS_W-1:0]     rdata_reg;
  logic [BUS_W-1:0]     rdata_next;

  // pad path
  logic [PIN_COUNT-1:0] pad_meta_reg;
  logic [PIN_COUNT-1:0] pad_sync_reg;
  logic [PIN_COUNT-1:0] pad_live;
  logic [PIN_COUNT-1:0] pad_out_reg;
  logic [PIN_COUNT-1:0] pad_out_next;
  logic [PIN_COUNT-1:0] pad_oe_reg;
  logic [PIN_COUNT-1:0] pad_oe_next;

  // host side
  host_side_s           host_side_reg;
  host_side_s           host_side_next;
  logic [DATA_PINS-1:0] low_addr_reg;
  logic [DATA_PINS-1:0] low_addr_next;

  // decode
  pin_mode_e            mode;
  logic                 host_en;
  logic                 mux_bus;
  logic                 double_stb;
  logic                 sel_control;
  logic                 sel_direction;
  logic                 sel_gpio_out;
  logic                 sel_level;
  logic                 sel_status;
  logic                 sel_any;

  // strobes
  logic [STROBE_COUNT-1:0] stb_level;
  logic [STROBE_COUNT-1:0] stb_invert;
  logic [STROBE_COUNT-1:0] stb_active;
  logic [STROBE_COUNT-1:0] stb_rise;
  logic                    stb_hold;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction

  // ---------------- register bus ----------------
  assign sel_control   = hit(bus_addr, OFS_PORT_CONTROL);
  assign sel_direction = hit(bus_addr, OFS_PIN_DIRECTION);
  assign sel_gpio_out  = hit(bus_addr, OFS_GPIO_OUT);
  assign sel_level     = hit(bus_addr, OFS_PIN_LEVEL);
  assign sel_status    = hit(bus_addr, OFS_STATUS);
  assign sel_any       = sel_control | sel_direction | sel_gpio_out | sel_level | sel_status;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      port_control_reg  <= PORT_CONTROL_RESET;
      pin_direction_reg <= PIN_DIRECTION_RESET;
      gpio_out_reg      <= GPIO_OUT_RESET;
    end else if (bus_write) begin
      if (sel_control) begin
        port_control_reg <= bus_wdata[PC_WIDTH-1:0];
      end
      if (sel_direction) begin
        pin_direction_reg <= bus_wdata[PIN_COUNT-1:0];
      end
      if (sel_gpio_out) begin
        gpio_out_reg <= bus_wdata[PIN_COUNT-1:0];
      end
    end
  end

  // read data stands only in the cycle after the strobe; unmapped reads return zero
  always_comb begin
    rdata_next = '0;
    if (bus_read) begin
      if (sel_control) begin
        rdata_next[PC_WIDTH-1:0] = port_control_reg;
      end
      if (sel_direction) begin
        rdata_next[PIN_COUNT-1:0] = pin_direction_reg;
      end
      if (sel_gpio_out) begin
        rdata_next[PIN_COUNT-1:0] = gpio_out_reg;
      end
      if (sel_level) begin
        rdata_next[PIN_COUNT-1:0] = pin_level_reg;
      end
      if (sel_status) begin
        rdata_next[1:0] = mode;
        rdata_next[2]   = stop_mode;
        rdata_next[STROBE_COUNT+2:3] = stb_active;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_reg <= '0;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign bus_rdata = rdata_reg;

  // ---------------- mode decode ----------------
  assign host_en    = port_control_reg[PC_HOST_EN];
  assign mux_bus    = port_control_reg[PC_MUX_BUS];
  assign double_stb = port_control_reg[PC_DOUBLE_STB];
  assign mode       = !host_en ? MODE_GPIO : (mux_bus ? MODE_HOST_MUX : MODE_HOST_PLAIN);

  // ---------------- pad input path ----------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pad_meta_reg <= '0;
      pad_sync_reg <= '0;
    end else begin
      pad_meta_reg <= pad_in;
      pad_sync_reg <= pad_meta_reg;
    end
  end

  // stop mode cuts every pin off from the core, not only gpio inputs
  assign pad_live = stop_mode ? '0 : pad_sync_reg;

  // pin level readback shows only gpio inputs; driven bits and host pins read zero
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_level_reg <= '0;
    end else begin
      pin_level_reg <= host_en ? '0 : (pad_live & ~pin_direction_reg);
    end
  end

  // ---------------- strobe conditioning ----------------
  // a disconnected strobe is fed its own inactive level so it never fires
  assign stb_invert[STB_ADDR] = ~port_control_reg[PC_ADDR_STB_HI];
  assign stb_invert[STB_READ] = ~port_control_reg[PC_READ_STB_HI];
  assign stb_invert[STB_DATA] = ~port_control_reg[PC_DATA_STB_HI];
  // outside the host function the strobes are held inactive too: the sync stage resets
  // low, which an active-low strobe would otherwise take for an edge after release
  assign stb_hold             = stop_mode || !host_en;
  assign stb_level[STB_ADDR]  = stb_hold ? stb_invert[STB_ADDR] : pad_sync_reg[PIN_A0_AS];
  assign stb_level[STB_READ]  = stb_hold ? stb_invert[STB_READ] : pad_sync_reg[PIN_RW_RD];
  assign stb_level[STB_DATA]  = stb_hold ? stb_invert[STB_DATA] : pad_sync_reg[PIN_DS_WR];

  strobe_shaper #(
    .WIDTH (STROBE_COUNT)
  ) u_strobe_shaper (
    .clk        (clk),
    .rst_b      (rst_b),
    .level_sync (stb_level),
    .invert     (stb_invert),
    .active     (stb_active),
    .rise       (stb_rise)
  );

  // ---------------- host side assembly ----------------
  // low address byte of a muxed cycle is caught when the address strobe goes active
  assign low_addr_next = (mode == MODE_HOST_MUX && stb_rise[STB_ADDR]) ?
                         pad_live[DATA_PINS-1:0] : low_addr_reg;

  always_comb begin
    host_side_next      = '0;
    host_side_next.data = host_en ? pad_live[DATA_PINS-1:0] : '0;
    unique case (mode)
      MODE_HOST_PLAIN: begin
        host_side_next.addr[0] = pad_live[PIN_A0_AS];
        host_side_next.addr[1] = pad_live[PIN_A1_A8];
        host_side_next.addr[2] = pad_live[PIN_A2_A9];
      end
      MODE_HOST_MUX: begin
        host_side_next.addr[DATA_PINS-1:0] = low_addr_reg;
        host_side_next.addr[8]          = pad_live[PIN_A1_A8];
        host_side_next.addr[9]          = pad_live[PIN_A2_A9];
        host_side_next.addr_strobe      = stb_active[STB_ADDR];
        host_side_next.addr_strobe_rise = stb_rise[STB_ADDR];
      end
      MODE_GPIO: begin
        host_side_next.addr = '0;
      end
      default: begin
        host_side_next.addr = '0;
      end
    endcase
    if (host_en && !double_stb) begin
      host_side_next.rw_select        = pad_live[PIN_RW_RD];
      host_side_next.data_strobe      = stb_active[STB_DATA];
      host_side_next.data_strobe_rise = stb_rise[STB_DATA];
    end
    if (host_en && double_stb) begin
      host_side_next.read_strobe       = stb_active[STB_READ];
      host_side_next.read_strobe_rise  = stb_rise[STB_READ];
      host_side_next.write_strobe      = stb_active[STB_DATA];
      host_side_next.write_strobe_rise = stb_rise[STB_DATA];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      host_side_reg <= '0;
      low_addr_reg  <= '0;
    end else begin
      host_side_reg <= host_side_next;
      low_addr_reg  <= low_addr_next;
    end
  end

  assign host_side = host_side_reg;

  // ---------------- pad output path ----------------
  // host mode: data pins follow the host register logic, control pins stay inputs
  genvar g;
  generate
    for (g = 0; g < PIN_COUNT; g++) begin : g_pad
      if (g < DATA_PINS) begin : g_data
        assign pad_oe_next[g]  = host_en ? host_drive.drive : pin_direction_reg[g];
        assign pad_out_next[g] = host_en ? host_drive.data[g] : gpio_out_reg[g];
      end else begin : g_ctrl
        assign pad_oe_next[g]  = !host_en && pin_direction_reg[g];
        assign pad_out_next[g] = !host_en && gpio_out_reg[g];
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pad_oe_reg  <= '0;
      pad_out_reg <= '0;
    end else begin
      pad_oe_reg  <= pad_oe_next;
      pad_out_reg <= pad_out_next;
    end
  end

  assign pad_oe  = pad_oe_reg;
  assign pad_out = pad_out_reg;

  // ---------------- assertions ----------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_control_steers_mode: assert property (
    bus_write && sel_control |=> host_en == $past(bus_wdata[PC_HOST_EN])
  ) else $error("port control write did not steer the pin function");

  a_plain_data_drive: assert property (
    host_en && !mux_bus && host_drive.drive |=> pad_oe[DATA_PINS-1:0] == '1
  ) else $error("host data pins not driven in plain bus mode");

  a_mux_low_addr: assert property (
    mode == MODE_HOST_MUX && stb_rise[STB_ADDR] && !stop_mode
    |=> ##1 host_side.addr[DATA_PINS-1:0] == $past(pad_sync_reg[DATA_PINS-1:0], 2)
  ) else $error("muxed low address byte not captured on address strobe");

  a_gpio_data_dir: assert property (
    !host_en |=> pad_oe[DATA_PINS-1:0] == $past(pin_direction_reg[DATA_PINS-1:0])
  ) else $error("gpio data pin direction does not follow direction register");

  a_ctrl_pins_input: assert property (
    host_en |=> pad_oe[PIN_COUNT-1:DATA_PINS] == '0
  ) else $error("control pin driven while host function selected");

  a_plain_addr_bits: assert property (
    mode == MODE_HOST_PLAIN && !stop_mode
    |=> host_side.addr[2:0] == $past(pad_sync_reg[PIN_A2_A9:PIN_A0_AS])
  ) else $error("plain bus address bits wrong");

  a_mux_high_addr: assert property (
    mode == MODE_HOST_MUX && !stop_mode
    |=> host_side.addr[9:8] == $past(pad_sync_reg[PIN_A2_A9:PIN_A1_A8])
  ) else $error("muxed bus address bits 8 and 9 wrong");

  a_rw_select_sample: assert property (
    host_en && !double_stb && !stop_mode |=> host_side.rw_select == $past(pad_sync_reg[PIN_RW_RD])
  ) else $error("read/write select not sampled from its pin");

  a_single_edge_rise: assert property (
    host_side.data_strobe_rise |-> host_side.data_strobe && !$past(host_side.data_strobe)
  ) else $error("data strobe rise without a fresh active level");

  a_double_no_ds: assert property (
    host_en && double_stb |=> !host_side.data_strobe && !host_side.rw_select
  ) else $error("single strobe outputs active in double strobe mode");

  a_stop_blanks_gpio: assert property (
    stop_mode |=> pin_level_reg == '0
  ) else $error("gpio input visible during stop mode");

  a_stop_no_strobe: assert property (
    stop_mode |=> stb_active == '0
  ) else $error("strobe active while pins are disconnected in stop mode");

  a_gpio_no_strobe: assert property (
    !host_en |=> stb_active == '0
  ) else $error("strobe active while gpio function selected");

  a_read_one_cycle: assert property (
    bus_read && sel_direction |=> bus_rdata[PIN_COUNT-1:0] == $past(pin_direction_reg)
  ) else $error("direction register read data wrong");

  a_unmapped_zero: assert property (
    bus_read && !sel_any |=> bus_rdata == '0
  ) else $error("unmapped read returned nonzero");

  c_gpio_output: cover property (!host_en && pin_direction_reg[0] ##1 pad_oe[0]);
  c_mux_addr_strobe: cover property (host_side.addr_strobe_rise);
  c_write_strobe: cover property (host_side.write_strobe_rise);
  c_stop_entry: cover property (!stop_mode ##1 stop_mode);

endmodule // host_port_pin_function_select

// >>> sim/host_bus_model.sv
// far-side host bus model: drives the pins set in host_en wherever the device does not; the rest float
`timescale 1ns/1ps
module host_bus_model
  import host_pin_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic [PIN_COUNT-1:0] host_val,
  input  wire logic [PIN_COUNT-1:0] host_en,
  input  wire logic [PIN_COUNT-1:0] pad_out,
  input  wire logic [PIN_COUNT-1:0] pad_oe,
  output logic      [PIN_COUNT-1:0] pad_in
);
  logic [PIN_COUNT-1:0] last_reg = '0;
  logic [PIN_COUNT-1:0] dev_lvl;
  logic [PIN_COUNT-1:0] far_lvl;
  logic [PIN_COUNT-1:0] float_lvl;

  // a floating pin flips every cycle, so a stale level never passes for a driven one
  assign dev_lvl   = pad_oe & pad_out;
  assign far_lvl   = ~pad_oe & host_en & host_val;
  assign float_lvl = ~pad_oe & ~host_en & ~last_reg;
  assign pad_in    = dev_lvl | far_lvl | float_lvl;

  always_ff @(posedge clk) begin
    last_reg <= pad_in;
  end
endmodule // host_bus_model

// >>> sim/tb_top.sv
// self-checking bench for the host-port pin function select
`timescale 1ns/1ps
module tb_top
  import host_pin_pkg::*;
;
  logic                 clk;
  logic                 rst_b;
  logic [ADDR_W-1:0]    bus_addr;
  logic [BUS_W-1:0]     bus_wdata;
  logic                 bus_write;
  logic                 bus_read;
  logic [BUS_W-1:0]     bus_rdata;
  logic                 stop_mode;
  host_drive_s          host_drive;
  host_side_s           host_side;
  logic [PIN_COUNT-1:0] pad_in;
  logic [PIN_COUNT-1:0] pad_out;
  logic [PIN_COUNT-1:0] pad_oe;
  logic [PIN_COUNT-1:0] host_val;
  logic [PIN_COUNT-1:0] host_en;
  logic [15:0]          rnd;
  logic [31:0]          mdl [5];
  int                   fails;
  int                   comparisons;

  host_port_pin_function_select i_dut (
    .clk(clk), .rst_b(rst_b), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_write(bus_write), .bus_read(bus_read), .bus_rdata(bus_rdata),
    .stop_mode(stop_mode), .host_drive(host_drive), .host_side(host_side),
    .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe)
  );

  host_bus_model i_host (
    .clk(clk), .host_val(host_val), .host_en(host_en),
    .pad_out(pad_out), .pad_oe(pad_oe), .pad_in(pad_in)
  );

  function automatic logic [15:0] lfsr_next(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction

  task automatic give_verdict();
    if (fails == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    bus_write <= 1'b1;
    bus_addr  <= a;
    bus_wdata <= d;
    @(posedge clk);
    bus_write <= 1'b0;
    // the model keeps only the implemented field width of each register
    if (a == OFS_PORT_CONTROL) mdl[0] = d & 32'h0000_003f;
    if (a == OFS_PIN_DIRECTION) mdl[1] = d & 32'h0000_1fff;
    if (a == OFS_GPIO_OUT) mdl[2] = d & 32'h0000_1fff;
  endtask

  task automatic rd(input logic [7:0] a, input string name, input logic [31:0] exp);
    @(posedge clk);
    bus_read <= 1'b1;
    bus_addr <= a;
    @(posedge clk);
    bus_read <= 1'b0;
    #1;
    chk(name, bus_rdata, exp);
  endtask

  function automatic logic [31:0] mode_of();
    return mdl[0][0] ? (mdl[0][1] ? 32'h0000_0002 : 32'h0000_0001) : 32'h0000_0000;
  endfunction

  // lane: 0 address, 1 read, 2 data, 3 write strobe
  task automatic wait_rise(input int lane, input string name);
    logic seen;
    seen = 1'b0;
    for (int i = 0; i < 8 && !seen; i++) begin
      cyc(1);
      case (lane)
        0: seen = host_side.addr_strobe_rise;
        1: seen = host_side.read_strobe_rise;
        2: seen = host_side.data_strobe_rise;
        default: seen = host_side.write_strobe_rise;
      endcase
    end
    chk(name, seen, 1);
  endtask

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  initial begin
    #(100 * 5000);
    fails++;
    give_verdict();
  end

  initial begin
    rst_b = 1'b0; bus_addr = '0; bus_wdata = '0; bus_write = 1'b0; bus_read = 1'b0;
    stop_mode = 1'b0; host_drive = '0; host_val = '0; host_en = '0;
    fails = 0; comparisons = 0; rnd = 16'h9bdb;
    for (int i = 0; i < 5; i++) mdl[i] = '0;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    cyc(2);
    chk("pad_oe", pad_oe, 0);
    rd(OFS_PORT_CONTROL, "control", 0);
    rd(OFS_PIN_DIRECTION, "direction", 0);
    rd(8'h20, "unmapped", 0);
    // gpio: random direction, output and far-side levels
    for (int k = 0; k < 4; k++) begin
      rnd = lfsr_next(rnd);
      wr(OFS_PIN_DIRECTION, {19'h0, rnd[12:0]});
      rnd = lfsr_next(rnd);
      wr(OFS_GPIO_OUT, {19'h0, rnd[12:0]});
      rnd = lfsr_next(rnd);
      host_val <= rnd[12:0];
      host_en  <= ~mdl[1][12:0];
      cyc(5);
      chk("gpio oe", pad_oe, mdl[1]);
      chk("gpio out", pad_out & mdl[1][12:0], mdl[2] & mdl[1]);
      chk("gpio host data", host_side.data, 0);
      rd(OFS_PIN_LEVEL, "pin level", {19'h0, rnd[12:0] & ~mdl[1][12:0]});
      rd(OFS_STATUS, "status", 0);
    end
    stop_mode <= 1'b1;
    cyc(5);
    rd(OFS_PIN_LEVEL, "stop level", 0);
    rd(OFS_STATUS, "stop status", 32'h0000_0004);
    stop_mode <= 1'b0;
    // control pins held at their inactive (high) level before the host function starts
    host_en  <= 13'h1f00;
    host_val <= 13'h1f00;
    // plain bus, single strobe, strobes active low
    wr(OFS_PORT_CONTROL, 32'h0000_0001);
    host_drive <= '{data: 8'ha5, drive: 1'b1};
    cyc(3);
    chk("host oe", pad_oe, 13'h00ff);
    chk("host out", pad_out[7:0], 8'ha5);
    rd(OFS_STATUS, "status", mode_of() & 32'h0000_0003);
    host_drive <= '{data: 8'h00, drive: 1'b0};
    host_en  <= 13'h1fff;
    host_val <= {1'b1, 1'b1, 3'b101, 8'h3c};
    cyc(6);
    chk("host data", host_side.data, 8'h3c);
    chk("plain addr", host_side.addr, 10'h005);
    chk("rw select", host_side.rw_select, 1);
    rd(OFS_PIN_LEVEL, "host level", 0);
    host_val[12] <= 1'b0;
    wait_rise(2, "data strobe");
    chk("data strobe level", host_side.data_strobe, 1);
    chk("no write strobe", host_side.write_strobe, 0);
    // plain bus, double strobe, strobes active high
    wr(OFS_PORT_CONTROL, 32'h0000_0035);
    host_val <= {2'b00, 3'b010, 8'h00};
    cyc(6);
    chk("double rw", host_side.rw_select, 0);
    host_val[11] <= 1'b1;
    wait_rise(1, "read strobe");
    chk("read strobe level", host_side.read_strobe, 1);
    host_val[12] <= 1'b1;
    wait_rise(3, "write strobe");
    chk("no data strobe", host_side.data_strobe, 0);
    // muxed bus, address strobe active high
    wr(OFS_PORT_CONTROL, 32'h0000_000b);
    host_val <= {2'b11, 2'b11, 1'b0, 8'h9e};
    cyc(6);
    rd(OFS_STATUS, "status", mode_of() & 32'h0000_0003);
    host_val[8] <= 1'b1;
    wait_rise(0, "address strobe");
    chk("address strobe level", host_side.addr_strobe, 1);
    cyc(2);
    chk("muxed addr", host_side.addr, 10'h39e);
    host_val[7:0] <= 8'h11;
    cyc(6);
    chk("muxed data", host_side.data, 8'h11);
    chk("latched addr", host_side.addr, 10'h39e);
    give_verdict();
  end
endmodule // tb_top
